// ==== hw/cct_mode_ctrl.sv ====
// mode logic around a can protocol core: retry disable, test gate, silent,
// loop back, basic mode buffers and transmit pin function select
// assumes a protocol core beside it that reports start, done, fail and receive
// events as one-cycle pulses on pclk, and an apb master on the register side
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps

module cct_mode_ctrl
  import cct_pkg::*;
#(
  parameter int NUM_OBJ = 32,               // message objects with flags
  parameter int SHIFT_W = 32,               // payload width of shift register
  parameter int OBJ_W   = $clog2(NUM_OBJ)
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               can_rx,
  output logic                    can_tx,
  input  wire logic               core_tx,
  output logic                    core_rx,
  input  wire logic               sample_point,
  input  wire logic               bus_idle,
  input  wire logic               tx_start,
  input  wire logic               tx_done,
  input  wire logic               tx_fail,
  input  wire logic               rx_done,
  input  wire logic [CCT_DLC_W-1:0] rx_dlc,
  input  wire logic [SHIFT_W-1:0] shift_data,
  input  wire logic               int_pending,
  output logic                    core_tx_req,
  output logic [OBJ_W-1:0]        core_tx_obj,
  output logic                    core_tx_load,
  output logic [SHIFT_W-1:0]      core_tx_data,
  output logic [CCT_DLC_W-1:0]    core_tx_dlc,
  output logic                    core_retry_en,
  output logic                    core_silent,
  output logic                    core_ack_ignore,
  output logic                    irq_n,
  output logic                    wait_n
);

  // ==========================================================
  // state
  logic [31:0]          ctrl_reg;      // control word
  logic [4:0]           test_reg;      // stored test bits, basic..pin high
  logic                 if1_busy_reg;  // first set pending and locked
  logic [CCT_DLC_W-1:0] if1_dlc_reg;
  logic [SHIFT_W-1:0]   if1_data_reg;
  logic                 if2_new_data_flag_reg;
  logic                 if2_message_lost_flag_reg;
  logic [CCT_DLC_W-1:0] if2_dlc_reg;
  logic [SHIFT_W-1:0]   if2_data_reg;
  logic [NUM_OBJ-1:0]   txrq_reg;      // transmit request per object
  logic [NUM_OBJ-1:0]   new_data_flag_reg;    // new data per object
  logic                 tx_active_reg; // object frame on the bus
  logic [OBJ_W-1:0]     cur_obj_reg;   // object being sent
  cct_btx_t             bstate_reg;
  cct_btx_t             bstate_next;
  logic [OBJ_W-1:0]     pick_obj;      // lowest pending object

  // ==========================================================
  // apb decode: one wait cycle so read data comes from a flop
  wire acc       = psel & penable & ce;
  wire take      = acc & pready;               // completing edge
  wire wr_en     = take & pwrite;
  wire hit_ctrl  = paddr == CCT_OFS_CTRL;
  wire hit_test  = paddr == CCT_OFS_TEST;
  wire hit_c1    = paddr == CCT_OFS_IF1_CMD;
  wire hit_l1    = paddr == CCT_OFS_IF1_CTL;
  wire hit_d1    = paddr == CCT_OFS_IF1_DATA;
  wire hit_c2    = paddr == CCT_OFS_IF2_CMD;
  wire hit_l2    = paddr == CCT_OFS_IF2_CTL;
  wire hit_d2    = paddr == CCT_OFS_IF2_DATA;
  wire hit_txrq  = paddr == CCT_OFS_TXRQ;
  wire hit_nd    = paddr == CCT_OFS_NEW_DATA_FLAG;
  wire mapped    = hit_ctrl | hit_test | hit_c1 | hit_l1 | hit_d1 | hit_c2 | hit_l2
                 | hit_d2 | hit_txrq | hit_nd;

  // ==========================================================
  // mode decode
  wire test_en   = ctrl_reg[CCT_CTRL_TEST_BIT];
  wire retry_disable       = ctrl_reg[CCT_CTRL_DAR_BIT];
  wire ie        = ctrl_reg[CCT_CTRL_IE_BIT];
  // test functions exist only while test is enabled; stored bits stay put
  wire basic     = test_en & test_reg[0];
  wire silent    = test_en & test_reg[1];
  wire loop_back_enable     = test_en & test_reg[2];
  wire [1:0] pin_sel = test_en ? test_reg[4:3] : CCT_PIN_NORMAL;
  wire busy_wdat = pwdata[CCT_CMD_BUSY_BIT];
  wire wr_c1     = wr_en & hit_c1;
  wire wr_c2     = wr_en & hit_c2;
  // the first set is locked while a basic transmission is pending
  wire if1_open  = ~(basic & if1_busy_reg);
  wire wr_txrq   = wr_en & hit_txrq;
  wire wr_nd     = wr_en & hit_nd;
  // objects never take part in basic mode
  wire obj_start = tx_start & ~basic & ~silent;
  wire obj_done  = tx_done & tx_active_reg;
  wire obj_fail  = tx_fail & tx_active_reg;

  // ==========================================================
  // pin routing
  logic tx_func;
  always_comb begin
    unique case (pin_sel)
      CCT_PIN_NORMAL: tx_func = core_tx;
      CCT_PIN_SAMPLE: tx_func = sample_point;
      CCT_PIN_DOM:    tx_func = CCT_DOMINANT;
      CCT_PIN_REC:    tx_func = CCT_RECESSIVE;
    endcase
  end
  // silent keeps the bus recessive whatever else is chosen
  wire can_tx_next  = silent ? CCT_RECESSIVE : tx_func;
  // loop back ignores the pin; silent alone lets own dominant bits be seen
  wire core_rx_next = loop_back_enable  ? core_tx
                    : silent ? (core_tx & can_rx)
                    : can_rx;

  // ==========================================================
  // read mux
  wire [31:0] rd_ctrl = ctrl_reg;
  wire [31:0] rd_test = {24'h0, can_rx, test_reg[4:3], test_reg[2:0], 2'h0};
  wire [31:0] rd_c1   = 32'(if1_busy_reg) << CCT_CMD_BUSY_BIT;
  wire [31:0] rd_l1   = 32'(if1_dlc_reg);
  // only flags and length show; every other control bit reads zero
  wire [31:0] rd_l2   = (32'(if2_new_data_flag_reg) << CCT_CTL_NEW_DATA_FLAG_BIT)
                      | (32'(if2_message_lost_flag_reg) << CCT_CTL_MESSAGE_LOST_FLAG_BIT)
                      | 32'(if2_dlc_reg);
  wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl
                      : hit_test ? rd_test
                      : hit_c1   ? rd_c1
                      : hit_l1   ? rd_l1
                      : hit_d1   ? 32'(if1_data_reg)
                      : hit_l2   ? rd_l2
                      : hit_d2   ? 32'(if2_data_reg)
                      : hit_txrq ? 32'(txrq_reg)
                      : hit_nd   ? 32'(new_data_flag_reg)
                      : CCT_RST_WORD;   // second command and unmapped read zero

  // ==========================================================
  // apb handshake and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= CCT_RST_WORD;
    end else if (ce) begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : prdata;
    end
  end

  // ==========================================================
  // control and test registers; test bits writable only in test mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CCT_RST_WORD;
      test_reg <= 5'h0;
    end else if (ce) begin
      if (wr_en & hit_ctrl) ctrl_reg <= pwdata;
      if (wr_en & hit_test & test_en) begin
        test_reg <= pwdata[CCT_TST_TXHI_BIT:CCT_TST_BASIC_BIT];
      end
    end
  end

  // ==========================================================
  // first set and basic transmit sequencer
  always_comb begin
    bstate_next = bstate_reg;
    unique case (bstate_reg)
      CCT_B_IDLE: if (basic & if1_busy_reg) bstate_next = CCT_B_PEND;
      // wait for an idle bus; silent never starts anything
      CCT_B_PEND: begin
        if (~if1_busy_reg | ~basic) bstate_next = CCT_B_IDLE;
        else if (bus_idle & ~silent) bstate_next = CCT_B_SEND;
      end
      CCT_B_SEND: begin
        if (tx_done) bstate_next = CCT_B_IDLE;
        // a failed frame retries only while busy still stands
        else if (tx_fail) bstate_next = (if1_busy_reg & ~retry_disable) ? CCT_B_PEND
                                                             : CCT_B_IDLE;
      end
      default: bstate_next = CCT_B_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bstate_reg   <= CCT_B_IDLE;
      if1_busy_reg <= 1'b0;
      if1_dlc_reg  <= '0;
      if1_data_reg <= '0;
    end else if (ce) begin
      bstate_reg <= bstate_next;
      // completion clears busy unless software sets it in the same cycle
      if (wr_c1) if1_busy_reg <= busy_wdat;
      else if (bstate_reg == CCT_B_SEND && (tx_done || (tx_fail && retry_disable)))
        if1_busy_reg <= 1'b0;
      if (wr_en & hit_l1 & if1_open) if1_dlc_reg  <= pwdata[CCT_DLC_W-1:0];
      if (wr_en & hit_d1 & if1_open) if1_data_reg <= pwdata[SHIFT_W-1:0];
    end
  end

  // ==========================================================
  // second set: receive buffer and shift register snapshot
  // a new frame wins over a software clear in the same cycle
  wire rx_copy = basic & (rx_done | (wr_c2 & busy_wdat));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      if2_new_data_flag_reg <= 1'b0;
      if2_message_lost_flag_reg <= 1'b0;
      if2_dlc_reg    <= '0;
      if2_data_reg   <= '0;
    end else if (ce) begin
      if (rx_copy) begin
        if2_data_reg <= shift_data;
        if2_dlc_reg  <= rx_dlc;
      end
      if (basic & rx_done) begin
        if2_new_data_flag_reg <= 1'b1;
        if2_message_lost_flag_reg <= if2_message_lost_flag_reg | if2_new_data_flag_reg;
      end else if (wr_en & hit_l2) begin
        if2_new_data_flag_reg <= pwdata[CCT_CTL_NEW_DATA_FLAG_BIT];
        if2_message_lost_flag_reg <= pwdata[CCT_CTL_MESSAGE_LOST_FLAG_BIT];
      end
    end
  end

  // ==========================================================
  // object flags: one slice per object
  for (genvar i = 0; i < NUM_OBJ; i++) begin : g_obj
    wire start_i = obj_start & (core_tx_obj == OBJ_W'(i));
    wire done_i  = obj_done & (cur_obj_reg == OBJ_W'(i));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        txrq_reg[i]   <= 1'b0;
        new_data_flag_reg[i] <= 1'b0;
      end else if (ce) begin
        // software writes win; only the hardware clears lose to them
        if (wr_txrq) txrq_reg[i] <= pwdata[i];
        else if (retry_disable & start_i) txrq_reg[i] <= 1'b0;
        else if (~retry_disable & done_i) txrq_reg[i] <= 1'b0;
        if (wr_nd) new_data_flag_reg[i] <= pwdata[i];
        else if (done_i) new_data_flag_reg[i] <= 1'b0;
      end
    end
  end

  // lowest numbered pending object goes first
  always_comb begin
    pick_obj = '0;
    for (int k = NUM_OBJ - 1; k >= 0; k--) begin
      if (txrq_reg[k]) pick_obj = OBJ_W'(k);
    end
  end

  // ==========================================================
  // core side outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_active_reg   <= 1'b0;
      cur_obj_reg     <= '0;
      core_tx_obj     <= '0;
      core_tx_req     <= 1'b0;
      core_tx_load    <= 1'b0;
      core_tx_data    <= '0;
      core_tx_dlc     <= '0;
      core_retry_en   <= 1'b1;
      core_silent     <= 1'b0;
      core_ack_ignore <= 1'b0;
      can_tx          <= CCT_RECESSIVE;
      core_rx         <= CCT_RECESSIVE;
      irq_n           <= 1'b1;
      wait_n          <= 1'b1;
    end else if (ce) begin
      if (obj_start) begin
        tx_active_reg <= 1'b1;
        cur_obj_reg   <= core_tx_obj;
      end else if (obj_done | obj_fail) begin
        tx_active_reg <= 1'b0;
      end
      if (~tx_active_reg) core_tx_obj <= pick_obj;
      // no request at all while silent
      core_tx_req  <= ~silent & (basic ? (bstate_next == CCT_B_SEND)
                                       : (|txrq_reg));
      core_tx_load <= (bstate_reg == CCT_B_PEND) & (bstate_next == CCT_B_SEND);
      if (bstate_reg == CCT_B_PEND) begin
        core_tx_data <= if1_data_reg;
        core_tx_dlc  <= if1_dlc_reg;
      end
      // retries end with retry disable or with a basic abort
      core_retry_en   <= ~retry_disable & ~(basic & ~if1_busy_reg);
      core_silent     <= silent;
      core_ack_ignore <= loop_back_enable;
      can_tx          <= can_tx_next;
      core_rx         <= core_rx_next;
      irq_n           <= ~(ie & int_pending);
      // handler wait only outside basic mode
      wait_n          <= basic | ~(acc & ~pready & (hit_c1 | hit_c2));
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence send_ends_s;
    ce && bstate_reg == CCT_B_SEND && tx_done && !wr_c1;
  endsequence
  sequence released_s;
    !if1_busy_reg && bstate_reg == CCT_B_IDLE;
  endsequence

  chk_silent_pin_rec: assert property (ce && silent |=> can_tx)
    else $error("bus pin not recessive in silent mode");
  chk_silent_no_req: assert property (ce && silent |=> !core_tx_req)
    else $error("transmit request raised in silent mode");
  chk_loop_back_enable_path: assert property (ce && loop_back_enable |=> core_rx == $past(core_tx))
    else $error("loop back path not feeding receive");
  chk_dar_start_clr: assert property (ce && retry_disable && obj_start && !wr_txrq
      |=> !txrq_reg[$past(core_tx_obj)])
    else $error("transmit request kept at start with retries off");
  chk_dar_fail_keep: assert property (ce && retry_disable && obj_fail && !wr_nd && !wr_txrq
      |=> new_data_flag_reg == $past(new_data_flag_reg) && txrq_reg == $past(txrq_reg))
    else $error("flags changed on failure with retries off");
  chk_retry_keeps: assert property (ce && !retry_disable && obj_fail && !wr_txrq
      |=> txrq_reg == $past(txrq_reg) ##1 core_retry_en || !ce)
    else $error("retry lost after failure");
  chk_basic_release: assert property (send_ends_s |=> released_s)
    else $error("first set not released after basic send");
  chk_basic_rx_copy: assert property (ce && basic && rx_done
      |=> if2_data_reg == $past(shift_data) && if2_new_data_flag_reg)
    else $error("received frame not copied to second set");
  chk_basic_wait_hi: assert property (ce && basic |=> wait_n)
    else $error("wait output low in basic mode");
  chk_test_off_pin: assert property (ce && !test_en |=> can_tx == $past(core_tx))
    else $error("test function active with test disabled");
  chk_irq_masked: assert property (ce && !ie |=> irq_n)
    else $error("interrupt output low while disabled");

endmodule : cct_mode_ctrl

// ==== hw/cct_pkg.sv ====
// constants, register map and state codes for the can test and retry mode block
// assumes a 32-bit apb slave with byte addresses of 8 bits
package cct_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CCT_OFS_CTRL     = 8'h00;  // retry disable, test, interrupt enable
  localparam logic [7:0] CCT_OFS_TEST     = 8'h04;  // test functions and receive pin mirror
  localparam logic [7:0] CCT_OFS_IF1_CMD  = 8'h08;  // first set command request
  localparam logic [7:0] CCT_OFS_IF1_CTL  = 8'h0c;  // first set message control
  localparam logic [7:0] CCT_OFS_IF1_DATA = 8'h10;  // first set payload
  localparam logic [7:0] CCT_OFS_IF2_CMD  = 8'h14;  // second set command request
  localparam logic [7:0] CCT_OFS_IF2_CTL  = 8'h18;  // second set message control
  localparam logic [7:0] CCT_OFS_IF2_DATA = 8'h1c;  // second set payload
  localparam logic [7:0] CCT_OFS_TXRQ     = 8'h20;  // per-object transmit request flags
  localparam logic [7:0] CCT_OFS_NEW_DATA_FLAG   = 8'h24;  // per-object new data flags

  // ==========================================================
  // field positions
  localparam int CCT_CTRL_IE_BIT   = 1;   // module interrupt enable
  localparam int CCT_CTRL_DAR_BIT  = 5;   // retry disable
  localparam int CCT_CTRL_TEST_BIT = 7;   // test enable
  localparam int CCT_TST_BASIC_BIT = 2;
  localparam int CCT_TST_SILENT_BIT = 3;
  localparam int CCT_TST_LOOP_BACK_ENABLE_BIT = 4;
  localparam int CCT_TST_TXLO_BIT  = 5;   // pin drive select low
  localparam int CCT_TST_TXHI_BIT  = 6;   // pin drive select high
  localparam int CCT_TST_RX_BIT    = 7;   // receive pin mirror, read only
  localparam int CCT_CMD_BUSY_BIT  = 15;
  localparam int CCT_CTL_NEW_DATA_FLAG_BIT = 15;
  localparam int CCT_CTL_MESSAGE_LOST_FLAG_BIT = 14;
  localparam int CCT_DLC_W         = 4;   // length code field width, lsb at bit 0

  // ==========================================================
  // reset values and levels
  localparam logic [31:0] CCT_RST_WORD = 32'h0000_0000;
  localparam logic        CCT_RECESSIVE = 1'b1;
  localparam logic        CCT_DOMINANT  = 1'b0;

  // pin drive select codes {high, low}
  localparam logic [1:0] CCT_PIN_NORMAL = 2'h0;  // serial data, reset state
  localparam logic [1:0] CCT_PIN_SAMPLE = 2'h1;  // sample point strobe
  localparam logic [1:0] CCT_PIN_DOM    = 2'h2;  // constant dominant
  localparam logic [1:0] CCT_PIN_REC    = 2'h3;  // constant recessive

  // basic mode transmit sequencer
  typedef enum logic [2:0] {
    CCT_B_IDLE = 3'b001,
    CCT_B_PEND = 3'b010,
    CCT_B_SEND = 3'b100
  } cct_btx_t;

endpackage : cct_pkg

// ==== verification/cct_bus_model.sv ====
// ==========================================================
// wired-and can bus with one other node, seen through a transceiver
// assumes recessive is high and the bus line has a pull-up
`timescale 1ns/10ps

module cct_bus_model (
  input  wire logic can_tx,      // our serial output pin
  input  wire logic node_drive,  // other node, 0 = dominant
  output logic      can_rx       // bus level back to our pin
);
  // any dominant node wins; an x on can_tx passes through, as no pull-up is modelled
  assign can_rx = can_tx & node_drive;
endmodule : cct_bus_model

// ==== verification/tb_top.sv ====
// self-checking bench: apb master, protocol core stand-in, bus model
// assumes one wait state per apb access and one 100 MHz clock
`timescale 1ns/10ps

module tb_top
  import cct_pkg::*;
();
  // ==========================================================
  // nets, all inputs valued at time zero
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, wlow = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, shift_data = 32'h0, core_tx_data;
  logic        pready, pslverr, can_rx, can_tx, core_rx, core_tx = 1'b1, node_drive = 1'b1;
  logic        sample_point = 1'b0, bus_idle = 1'b0, int_pending = 1'b0;
  logic        tx_start = 1'b0, tx_done = 1'b0, tx_fail = 1'b0, rx_done = 1'b0;
  logic [3:0]  rx_dlc = 4'h0, core_tx_dlc;
  logic [4:0]  core_tx_obj;
  logic        core_tx_req, core_tx_load, core_retry_en, core_silent, core_ack_ignore;
  logic        irq_n, wait_n;
  int          err_total = 0, num_checks = 0;

  always #5 pclk = ~pclk;  // 100 MHz

  cct_mode_ctrl i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .can_rx, .can_tx, .core_tx, .core_rx, .sample_point,
    .bus_idle, .tx_start, .tx_done, .tx_fail, .rx_done, .rx_dlc, .shift_data, .int_pending,
    .core_tx_req, .core_tx_obj, .core_tx_load, .core_tx_data, .core_tx_dlc, .core_retry_en,
    .core_silent, .core_ack_ignore, .irq_n, .wait_n);
  cct_bus_model i_bus (.can_tx, .node_drive, .can_rx);

  // ==========================================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; entered and left at a rising edge, request held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // values read right after the edge are those the edge sampled
    do begin
      @(posedge pclk);
      n++;
      if (wait_n !== 1'b1) wlow = 1'b1;  // any wait pulse seen during the access
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;  // taken at the completing edge only
    last_err = pslverr;
    if (pready !== 1'b1) begin
      err_total++;
      close_out();
    end
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdc

  // let registered pins settle, then look between edges
  task automatic mid();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask : mid

  // one-cycle core event: 0 start, 1 done, 2 fail, 3 receive
  task automatic pulse(input int k);
    {rx_done, tx_fail, tx_done, tx_start} <= 4'h1 << k;
    @(posedge pclk);
    {rx_done, tx_fail, tx_done, tx_start} <= 4'h0;
    repeat (2) @(posedge pclk);
  endtask : pulse

  // ==========================================================
  // scenarios
  task automatic t_reset();
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("can_tx rst", can_tx, 1'b1);
    chk("irq_n rst", irq_n, 1'b1);
    chk("retry rst", core_retry_en, 1'b1);
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("ctrl rst", CCT_OFS_CTRL, 32'h0);
    rdc("test rst", CCT_OFS_TEST, 32'h80);
    core_tx <= 1'b0;
    mid();
    chk("pin normal", can_tx, 1'b0);
    @(posedge pclk);
  endtask : t_reset

  task automatic t_gate();
    wr(CCT_OFS_TEST, 32'h08);
    rdc("test locked", CCT_OFS_TEST, 32'h00);
    wr(CCT_OFS_CTRL, 32'h80);
    wr(CCT_OFS_TEST, 32'h08);
    rdc("test open", CCT_OFS_TEST, 32'h88);
    mid();
    chk("silent pin", can_tx, 1'b1);
    @(posedge pclk);
    wr(CCT_OFS_CTRL, 32'h0);
    mid();
    chk("gate off", can_tx, 1'b0);
    @(posedge pclk);
  endtask : t_gate

  // every silent and loop back setting against every pin and bus level, then all pin functions
  task automatic t_pins();
    logic [1:0] m;
    logic       ex_tx;
    wr(CCT_OFS_CTRL, 32'h80);
    for (int i = 0; i < 16; i++) begin
      m = i[3:2];
      wr(CCT_OFS_TEST, {27'h0, m, 3'h0});
      {core_tx, node_drive} <= i[1:0];
      mid();
      ex_tx = m[0] ? 1'b1 : i[1];  // silent forces recessive
      chk("pin tx", can_tx, ex_tx);
      chk("core rx", core_rx, m[1] ? i[1] : i[1] & i[0]);
      chk("ack ignore", core_ack_ignore, m[1]);
      chk("silent out", core_silent, m[0]);
      @(posedge pclk);
    end
    for (int i = 0; i < 8; i++) begin
      wr(CCT_OFS_TEST, {25'h0, i[1:0], 5'h0});
      {core_tx, sample_point} <= {i[2], ~i[2]};
      mid();
      ex_tx = (i[1:0] == 2'h0) ? i[2] : (i[1:0] == 2'h1) ? ~i[2] : i[0];
      chk("pin func", can_tx, ex_tx);
      @(posedge pclk);
    end
    {core_tx, node_drive} <= 2'b11;
    wr(CCT_OFS_TEST, 32'h0);
  endtask : t_pins

  task automatic t_retry();
    wr(CCT_OFS_CTRL, 32'h20);
    wr(CCT_OFS_TXRQ, 32'h8);
    wr(CCT_OFS_NEW_DATA_FLAG, 32'h8);
    chk("retry off", core_retry_en, 1'b0);
    chk("obj pick", core_tx_obj, 5'd3);
    pulse(0);
    rdc("txrq start", CCT_OFS_TXRQ, 32'h0);
    rdc("new_data_flag start", CCT_OFS_NEW_DATA_FLAG, 32'h8);
    pulse(2);
    rdc("new_data_flag fail", CCT_OFS_NEW_DATA_FLAG, 32'h8);
    rdc("txrq fail", CCT_OFS_TXRQ, 32'h0);
    wr(CCT_OFS_TXRQ, 32'h8);
    pulse(0);
    pulse(1);
    rdc("new_data_flag done", CCT_OFS_NEW_DATA_FLAG, 32'h0);
    wr(CCT_OFS_CTRL, 32'h0);
    wr(CCT_OFS_TXRQ, 32'h1);
    wr(CCT_OFS_NEW_DATA_FLAG, 32'h1);
    chk("retry on", core_retry_en, 1'b1);
    pulse(0);
    pulse(2);
    rdc("txrq kept", CCT_OFS_TXRQ, 32'h1);
    pulse(0);
    pulse(1);
    rdc("txrq conf", CCT_OFS_TXRQ, 32'h0);
    rdc("new_data_flag conf", CCT_OFS_NEW_DATA_FLAG, 32'h0);
    wr(CCT_OFS_CTRL, 32'ha0);
    wr(CCT_OFS_TEST, 32'h08);
    wr(CCT_OFS_TXRQ, 32'h2);
    pulse(0);
    rdc("silent start", CCT_OFS_TXRQ, 32'h2);
    chk("silent req", core_tx_req, 1'b0);
    wr(CCT_OFS_TEST, 32'h0);
  endtask : t_retry

  task automatic t_basic();
    int n;
    n = 0;
    wr(CCT_OFS_CTRL, 32'h80);
    wr(CCT_OFS_TEST, 32'h04);
    wr(CCT_OFS_IF1_DATA, 32'hcafe_0123);
    wr(CCT_OFS_IF1_CTL, 32'h6);
    wlow = 1'b0;
    wr(CCT_OFS_IF1_CMD, 32'h8005);
    wr(CCT_OFS_IF1_DATA, 32'h0);
    rdc("if1 locked", CCT_OFS_IF1_DATA, 32'hcafe_0123);
    chk("wait held", wlow, 1'b0);
    bus_idle <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (core_tx_load !== 1'b1 && n < 20);
    chk("load", core_tx_load, 1'b1);
    chk("load data", core_tx_data, 32'hcafe_0123);
    chk("load dlc", core_tx_dlc, 4'h6);
    chk("basic req", core_tx_req, 1'b1);
    // a load that never came is already counted; stop here
    if (core_tx_load !== 1'b1) close_out();
    @(posedge pclk);
    bus_idle <= 1'b0;
    pulse(1);
    apb(1'b0, CCT_OFS_IF1_CMD, 32'h0);
    chk("busy done", rd[15], 1'b0);
    {shift_data, rx_dlc} <= {32'h1234_5678, 4'h5};
    pulse(3);
    rdc("if2 data", CCT_OFS_IF2_DATA, 32'h1234_5678);
    rdc("if2 ctl", CCT_OFS_IF2_CTL, 32'h8005);
    pulse(3);
    rdc("if2 lost", CCT_OFS_IF2_CTL, 32'hc005);
    shift_data <= 32'h0bad_f00d;
    wr(CCT_OFS_IF2_CMD, 32'h8000);
    rdc("if2 snap", CCT_OFS_IF2_DATA, 32'h0bad_f00d);
    wr(CCT_OFS_IF1_CMD, 32'h8000);
    mid();
    chk("retry pending", core_retry_en, 1'b1);
    @(posedge pclk);
    wr(CCT_OFS_IF1_CMD, 32'h0);
    // retry enable is registered: look once it has settled
    mid();
    chk("abort retry", core_retry_en, 1'b0);
    @(posedge pclk);
    apb(1'b0, CCT_OFS_IF1_CMD, 32'h0);
    chk("abort busy", rd[15], 1'b0);
  endtask : t_basic

  task automatic t_misc();
    int_pending <= 1'b1;
    wr(CCT_OFS_CTRL, 32'h0);
    mid();
    chk("irq masked", irq_n, 1'b1);
    @(posedge pclk);
    wr(CCT_OFS_CTRL, 32'h2);
    mid();
    chk("irq low", irq_n, 1'b0);
    @(posedge pclk);
    int_pending <= 1'b0;
    mid();
    chk("irq clear", irq_n, 1'b1);
    @(posedge pclk);
    // clock enable low must freeze the interrupt output
    ce <= 1'b0;
    int_pending <= 1'b1;
    mid();
    chk("ce freeze", irq_n, 1'b1);
    @(posedge pclk);
    {ce, int_pending} <= 2'b10;
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", last_err, 1'b1);
    chk("unmapped data", rd, 32'h0);
  endtask : t_misc

  // ==========================================================
  // main sequence
  initial begin
    t_reset();
    t_gate();
    t_pins();
    t_retry();
    t_basic();
    t_misc();
    close_out();
  end
endmodule : tb_top
